// ===== sitd_top.sv
// Slave image decode, translation and local error log, with APB registers.
// Assumes access strobes from the local bus interface on ref_clk and pins pre-synced here.
`timescale 1ns/1ps
`default_nettype none
module sitd_top
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pciRstN,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bridge_chip_select_n,
  input wire logic slave_image_select,
  input wire logic accStart,
  input wire logic accWrite,
  input wire logic accBurst,
  input wire logic [31:0] accAddr,
  output logic [2:0] accResp,
  output logic accRespValid,
  output logic [31:0] pciAddrOut,
  input wire logic img0LoadValid,
  input wire logic [31:0] img0LoadCtl,
  input wire logic [31:0] img0LoadAt,
  input wire logic fifoWrErr,
  input wire logic [3:0] fifoTxnCode,
  input wire logic [1:0] fifoSizeCode,
  input wire logic [31:0] fifoAddr,
  input wire logic [31:0] fifoData,
  output logic irq
);
  logic [31:0] img0Ctl_reg;
  logic [31:0] img0At_reg;
  logic [31:0] img1Ctl_reg;
  logic [31:0] img1At_reg;
  logic logEn_reg;
  logic error_logged_flag_reg;
  logic [3:0] logged_txn_code_reg;
  logic [1:0] logged_size_code_reg;
  logic [31:0] logAddr_reg;
  logic [31:0] logData_reg;
  logic [1:0] irqStat_reg;
  logic [1:0] irqMask_reg;
  logic img0Loaded_reg;
  logic [1:0] pciRstSync_reg;
  logic [1:0] csSync_reg;
  logic [1:0] selSync_reg;
  logic apbWr;
  logic apbRd;
  logic mapped;
  logic [31:0] rdValue;
  logic [31:0] selCtl;
  logic [31:0] selAt;
  logic [31:0] xlAddr;
  logic posted_write_allow;
  logic pci_space_select;
  logic prefetch_read_allow;
  logic esClearWrite;
  logic berrEvent;
  sitd_pkg::sitd_resp_t respNext;

  // Pins and the PCI reset are asynchronous to ref_clk
  // Chip select resets deasserted so nothing decodes while the sync fills
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pciRstSync_reg <= 2'h0;
      csSync_reg <= 2'h3;
      selSync_reg <= 2'h0;
    end
    else
    begin
      pciRstSync_reg <= {pciRstSync_reg[0], pciRstN};
      csSync_reg <= {csSync_reg[0], bridge_chip_select_n};
      selSync_reg <= {selSync_reg[0], slave_image_select};
    end
  end

  // Writes land in the access cycle; reads are captured a cycle earlier in setup
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;

  // Unmapped offsets answer with pslverr and their writes are dropped
  function automatic logic isMapped(input logic [11:0] a);
    unique case (a)
      sitd_pkg::OFF_IMG0_CTL, sitd_pkg::OFF_IMG0_AT, sitd_pkg::OFF_IMG1_CTL,
      sitd_pkg::OFF_IMG1_AT, sitd_pkg::OFF_ERRCS, sitd_pkg::OFF_AERR,
      sitd_pkg::OFF_DERR, sitd_pkg::OFF_IRQ_STAT, sitd_pkg::OFF_IRQ_MASK,
      sitd_pkg::OFF_IMG0_LOAD: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  assign mapped = isMapped(paddr);
  assign esClearWrite = apbWr && (paddr == sitd_pkg::OFF_ERRCS) && pwdata[sitd_pkg::ERR_ES_BIT];

  // Image 0 lives in the PCI reset domain and can be loaded at start-up
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || !pciRstSync_reg[1])
    begin
      img0Ctl_reg <= sitd_pkg::CTL_RESET;
      img0At_reg <= sitd_pkg::AT_RESET;
      img0Loaded_reg <= 1'b0;
    end
    else if (img0LoadValid)
    begin
      // Prefetch enable is never loaded, the load clears it to its reset value of 0
      img0Ctl_reg <= img0LoadCtl & sitd_pkg::CTL_MASK &
                     ~(32'h1 << sitd_pkg::CTL_PREFETCH_READ_ALLOW_BIT);
      img0At_reg <= img0LoadAt & sitd_pkg::AT_MASK;
      img0Loaded_reg <= 1'b1;
    end
    else if (apbWr && paddr == sitd_pkg::OFF_IMG0_CTL)
    begin
      img0Ctl_reg <= pwdata & sitd_pkg::CTL_MASK;
    end
    else if (apbWr && paddr == sitd_pkg::OFF_IMG0_AT)
    begin
      img0At_reg <= pwdata & sitd_pkg::AT_MASK;
    end
  end

  // Image 1 has no load path at all
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      img1Ctl_reg <= sitd_pkg::CTL_RESET;
      img1At_reg <= sitd_pkg::AT_RESET;
    end
    else
    begin
      if (apbWr && paddr == sitd_pkg::OFF_IMG1_CTL)
      begin
        img1Ctl_reg <= pwdata & sitd_pkg::CTL_MASK;
      end
      if (apbWr && paddr == sitd_pkg::OFF_IMG1_AT)
      begin
        img1At_reg <= pwdata & sitd_pkg::AT_MASK;
      end
    end
  end

  // Image choice
  always_comb
  begin
    if (selSync_reg[1])
    begin
      selCtl = img1Ctl_reg;
      selAt = img1At_reg;
    end
    else
    begin
      selCtl = img0Ctl_reg;
      selAt = img0At_reg;
    end
  end

  assign posted_write_allow = selCtl[sitd_pkg::CTL_POSTED_WRITE_ALLOW_BIT];
  assign pci_space_select = selCtl[sitd_pkg::CTL_PAS_BIT];
  assign prefetch_read_allow = selCtl[sitd_pkg::CTL_PREFETCH_READ_ALLOW_BIT];

  // I/O images never burst, and single I/O writes are never posted
  always_comb
  begin
    unique case ({accWrite, accBurst})
      2'b00: respNext = (prefetch_read_allow && !pci_space_select) ?
                        sitd_pkg::RSP_DLY_PF_READ : sitd_pkg::RSP_DLY_READ;
      2'b01: respNext = pci_space_select ?
                        sitd_pkg::RSP_BUS_ERROR : sitd_pkg::RSP_DLY_READ;
      2'b10: respNext = (posted_write_allow && !pci_space_select) ?
                        sitd_pkg::RSP_POST_WRITE : sitd_pkg::RSP_DLY_WRITE;
      2'b11: respNext = pci_space_select ?
                        sitd_pkg::RSP_BUS_ERROR : sitd_pkg::RSP_POST_WRITE;
    endcase
  end

  // Low 16 lines always pass; only the block above the size code is replaced
  sitd_xlate u_xlate
  (
    .localAddr(accAddr),
    .translationBase(selAt[sitd_pkg::AT_TA_LSB +: 16]),
    .blockSizeCode(selAt[sitd_pkg::AT_BS_LSB +: 4]),
    .xlateEn(selAt[sitd_pkg::AT_EN_BIT]),
    .pciAddr(xlAddr)
  );

  // Decode only while the chip select pin is low
  assign berrEvent = accStart && !csSync_reg[1] && (respNext == sitd_pkg::RSP_BUS_ERROR);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      accResp <= sitd_pkg::RSP_NONE;
      accRespValid <= 1'b0;
      pciAddrOut <= 32'h00000000;
    end
    else if (accStart && !csSync_reg[1])
    begin
      accResp <= respNext;
      accRespValid <= 1'b1;
      pciAddrOut <= xlAddr;
    end
    else
    begin
      accRespValid <= 1'b0;
    end
  end

  // Error log: first error held until software clears the flag
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      logEn_reg <= 1'b0;
      error_logged_flag_reg <= 1'b0;
      logged_txn_code_reg <= 4'h0;
      logged_size_code_reg <= 2'h0;
      logAddr_reg <= 32'h00000000;
      logData_reg <= 32'h00000000;
    end
    else
    begin
      if (apbWr && paddr == sitd_pkg::OFF_ERRCS)
      begin
        // Software must clear the flag in the same write that drops enable
        logEn_reg <= pwdata[sitd_pkg::ERR_EN_BIT];
      end
      if (fifoWrErr && logEn_reg && !error_logged_flag_reg)
      begin
        error_logged_flag_reg <= 1'b1;
        logged_txn_code_reg <= fifoTxnCode;
        logged_size_code_reg <= fifoSizeCode;
        logAddr_reg <= fifoAddr;
        logData_reg <= fifoData;
      end
      else if (esClearWrite)
      begin
        error_logged_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt status, set wins over a clearing write
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (apbWr && paddr == sitd_pkg::OFF_IRQ_MASK)
      begin
        irqMask_reg <= pwdata[1:0] & sitd_pkg::IRQ_MASK_BITS;
      end
      irqStat_reg <= (irqStat_reg &
                      ~((apbWr && paddr == sitd_pkg::OFF_IRQ_STAT) ? pwdata[1:0] : 2'h0)) |
                     {berrEvent, fifoWrErr && logEn_reg && !error_logged_flag_reg};
      // Follows the registered status, so irq rises one cycle after the status bit sets, two after the event
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

  // Read mux
  always_comb
  begin
    rdValue = 32'h00000000;
    unique case (paddr)
      sitd_pkg::OFF_IMG0_CTL: rdValue = img0Ctl_reg;
      sitd_pkg::OFF_IMG0_AT: rdValue = img0At_reg;
      sitd_pkg::OFF_IMG1_CTL: rdValue = img1Ctl_reg;
      sitd_pkg::OFF_IMG1_AT: rdValue = img1At_reg;
      sitd_pkg::OFF_ERRCS:
      begin
        rdValue[sitd_pkg::ERR_EN_BIT] = logEn_reg;
        rdValue[sitd_pkg::ERR_ES_BIT] = error_logged_flag_reg;
        if (error_logged_flag_reg)
        begin
          rdValue[sitd_pkg::ERR_TC_LSB +: 4] = logged_txn_code_reg;
          rdValue[sitd_pkg::ERR_SIZ_LSB +: 2] = logged_size_code_reg;
        end
      end
      // Address log stays hidden while no error is logged
      sitd_pkg::OFF_AERR: rdValue = error_logged_flag_reg ? logAddr_reg : 32'h00000000;
      sitd_pkg::OFF_DERR: rdValue = logData_reg;
      sitd_pkg::OFF_IRQ_STAT: rdValue = {30'h0, irqStat_reg};
      sitd_pkg::OFF_IRQ_MASK: rdValue = {30'h0, irqMask_reg};
      sitd_pkg::OFF_IMG0_LOAD: rdValue = {31'h0, img0Loaded_reg};
      default: rdValue = 32'h00000000;
    endcase
  end

  // Read data captured in setup, answered in the first access cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (apbRd)
      begin
        prdata <= rdValue;
      end
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end
endmodule
`default_nettype wire

// ===== sitd_pkg.sv
// Package for the slave image decode and translate block.
// Assumes a 32-bit APB register port; offsets are byte addresses.
package sitd_pkg;
  localparam logic [11:0] OFF_IMG0_CTL = 12'hF00;
  localparam logic [11:0] OFF_IMG0_AT = 12'hF04;
  localparam logic [11:0] OFF_IMG1_CTL = 12'hF10;
  localparam logic [11:0] OFF_IMG1_AT = 12'hF14;
  localparam logic [11:0] OFF_ERRCS = 12'hF80;
  localparam logic [11:0] OFF_AERR = 12'hF84;
  localparam logic [11:0] OFF_DERR = 12'hF88;
  localparam logic [11:0] OFF_IRQ_STAT = 12'hF90;
  localparam logic [11:0] OFF_IRQ_MASK = 12'hF94;
  localparam logic [11:0] OFF_IMG0_LOAD = 12'hF98;
  localparam int CTL_POSTED_WRITE_ALLOW_BIT = 31;
  localparam int CTL_PAS_BIT = 24;
  localparam int CTL_PREFETCH_READ_ALLOW_BIT = 23;
  localparam int AT_TA_LSB = 16;
  localparam int AT_BS_LSB = 4;
  localparam int AT_EN_BIT = 0;
  localparam int ERR_EN_BIT = 31;
  localparam int ERR_ES_BIT = 24;
  localparam int ERR_TC_LSB = 4;
  localparam int ERR_SIZ_LSB = 0;
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_BERR_BIT = 1;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  localparam logic [31:0] AT_RESET = 32'h00000000;
  localparam logic [31:0] CTL_MASK = 32'h81800000;
  localparam logic [31:0] AT_MASK = 32'hFFFF00F1;
  localparam logic [1:0] IRQ_MASK_BITS = 2'h3;
  typedef enum logic [2:0]
  {
    RSP_NONE = 3'b000,
    RSP_DLY_READ = 3'b001,
    RSP_DLY_PF_READ = 3'b010,
    RSP_DLY_WRITE = 3'b011,
    RSP_POST_WRITE = 3'b100,
    RSP_BUS_ERROR = 3'b101
  } sitd_resp_t;
endpackage

// ===== sitd_xlate.sv
// Address translation for one slave image.
// Assumes the block size code selects the lowest translated line.
`timescale 1ns/1ps
`default_nettype none
module sitd_xlate
(
  input wire logic [31:0] localAddr,
  input wire logic [15:0] translationBase,
  input wire logic [3:0] blockSizeCode,
  input wire logic xlateEn,
  output logic [31:0] pciAddr
);
  logic [15:0] keepMask;
  always_comb
  begin
    // Lines A(16+code) and up come from the base
    keepMask = 16'hFFFF << blockSizeCode;
    if (xlateEn)
    begin
      pciAddr = {(translationBase & keepMask) | (localAddr[31:16] & ~keepMask),
                 localAddr[15:0]};
    end
    else
    begin
      pciAddr = localAddr;
    end
  end
endmodule
`default_nettype wire

// ===== sitd_monitor.sv
// Port checker for the slave image decode block.
// Assumes binding onto sitd_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sitd_monitor
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic bridge_chip_select_n,
  input wire logic accStart,
  input wire logic accWrite,
  input wire logic accBurst,
  input wire logic [31:0] accAddr,
  input wire logic [2:0] accResp,
  input wire logic accRespValid,
  input wire logic [31:0] pciAddrOut
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Chip select passes two sync flops, so the start edge sees it two edges late
  AST_RESP_CAUSE: assert property (accRespValid |-> $past(accStart) && !$past(bridge_chip_select_n, 3))
    else $error("response without a selected start");
  AST_NOT_SELECTED: assert property (accStart && $past(bridge_chip_select_n, 2) |=> !accRespValid)
    else $error("response while deselected");
  AST_SGL_RD: assert property (accRespValid && !$past(accBurst) && !$past(accWrite)
    |-> accResp inside {3'h1, 3'h2})
    else $error("bad single read response");
  AST_BST_RD: assert property (accRespValid && $past(accBurst) && !$past(accWrite)
    |-> accResp inside {3'h1, 3'h5})
    else $error("bad burst read response");
  AST_SGL_WR: assert property (accRespValid && !$past(accBurst) && $past(accWrite)
    |-> accResp inside {3'h3, 3'h4})
    else $error("bad single write response");
  AST_BST_WR: assert property (accRespValid && $past(accBurst) && $past(accWrite)
    |-> accResp inside {3'h4, 3'h5})
    else $error("bad burst write response");
  AST_LOW_ADDR: assert property (accRespValid
    |-> ((pciAddrOut ^ $past(accAddr)) & 32'h0000FFFF) == 32'h00000000)
    else $error("low address lines altered");
  AST_LOG_GATE: assert property (psel && penable && pready && !pwrite
    && paddr == sitd_pkg::OFF_ERRCS && !prdata[24] |-> prdata[7:0] == 8'h00)
    else $error("log fields visible without error flag");
endmodule
`default_nettype wire

// ===== sitd_lbm.sv
// Local bus master model issuing decode requests.
// Assumes one clock; pins change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module sitd_lbm
(
  input wire logic ref_clk,
  output logic csN,
  output logic imgSel,
  output logic start,
  output logic wr,
  output logic burst,
  output logic [31:0] addr
);
  initial
  begin
    {csN, imgSel, start, wr, burst} = 5'h10;
    addr = 32'h00000000;
  end
  // Selects lead the start by three edges so the pin syncs have settled
  task automatic access(input logic c, input logic s, input logic w, input logic b,
    input logic [31:0] a);
    @(posedge ref_clk);
    csN <= c;
    imgSel <= s;
    repeat (3) @(posedge ref_clk);
    {start, wr, burst, addr} <= {1'b1, w, b, a};
    @(posedge ref_clk);
    // Released lines show inverted values so a late sample cannot match by luck
    {start, wr, burst, addr} <= {1'b0, ~w, ~b, ~a};
    csN <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb_slave_image_translate_decode.sv
// Testbench for the slave image decode and translate block.
// Assumes the package, design, checker and master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_slave_image_translate_decode;
  logic ref_clk, nrst, pciRstN, psel, penable, pwrite, pready, pslverr, irq, lastErr;
  logic bridge_chip_select_n, slave_image_select, accStart, accWrite, accBurst, accRespValid;
  logic img0LoadValid, fifoWrErr;
  logic [1:0] fifoSizeCode;
  logic [2:0] accResp;
  logic [3:0] fifoTxnCode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, accAddr, pciAddrOut, img0LoadCtl, img0LoadAt, fifoAddr, fifoData;
  logic [31:0] ctl[2], at[2];
  logic [34:0] qd[$];
  logic [31:0] qr[$];
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 17;
  sitd_top uut (.ref_clk, .nrst, .pciRstN, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .bridge_chip_select_n, .slave_image_select, .accStart,
    .accWrite, .accBurst, .accAddr, .accResp, .accRespValid, .pciAddrOut, .img0LoadValid,
    .img0LoadCtl, .img0LoadAt, .fifoWrErr, .fifoTxnCode, .fifoSizeCode, .fifoAddr,
    .fifoData, .irq);
  sitd_lbm lbm (.ref_clk, .csN(bridge_chip_select_n), .imgSel(slave_image_select),
    .start(accStart), .wr(accWrite), .burst(accBurst), .addr(accAddr));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Results are sampled before the edge updates land, as the master sees them
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_fail++;
      tally_and_finish();
    end
    else
    begin
      if (accRespValid !== 1'b0)
        chk({accResp, pciAddrOut}, qd.size() ? qd.pop_front() : 35'h7FFFFFFFF);
      if (psel && penable && pready && !pwrite)
        chk(prdata, qr.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    lastErr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    qr.push_back(e);
    apb(1'b0, a, e);
  endtask
  task automatic dec(input logic s, input logic w, input logic b, input logic [31:0] a);
    logic [2:0] r;
    logic [31:0] m;
    r = b ? (ctl[s][24] ? 3'h5 : (w ? 3'h4 : 3'h1)) : w ? ((ctl[s][31] && !ctl[s][24])
      ? 3'h4 : 3'h3) : ((ctl[s][23] && !ctl[s][24]) ? 3'h2 : 3'h1);
    m = at[s][0] ? 32'hFFFFFFFF << (16 + at[s][7:4]) : 32'h00000000;
    qd.push_back({r, (a & ~m) | (at[s] & m)});
    lbm.access(1'b0, s, w, b, a);
  endtask
  task automatic fe();
    fifoWrErr <= 1'b1;
    @(posedge ref_clk);
    fifoWrErr <= 1'b0;
  endtask
  initial
  begin
    {nrst, pciRstN, psel, penable, pwrite, img0LoadValid, fifoWrErr} = 7'h00;
    {paddr, pwdata, img0LoadCtl, img0LoadAt, fifoAddr, fifoData} = '0;
    {fifoTxnCode, fifoSizeCode} = 6'h2A;
    repeat (4) @(posedge ref_clk);
    {nrst, pciRstN, fifoAddr, fifoData} <= {2'b11, $random(seed), $random(seed)};
    repeat (3) @(posedge ref_clk);
    rd(sitd_pkg::OFF_IMG1_CTL, 32'h00000000);
    rd(sitd_pkg::OFF_IMG1_AT, 32'h00000000);
    rd(sitd_pkg::OFF_IMG0_AT, 32'h00000000);
    rd(sitd_pkg::OFF_ERRCS, 32'h00000000);
    for (int k = 0; k < 64; k++)
    begin
      {ctl[0], ctl[1], at[0], at[1]} = {$random(seed), $random(seed), $random(seed), $random(seed)};
      ctl[k[5]] = {k[0], 6'h00, k[1], k[2], 23'h000000};
      at[k[5]][7:4] = k[3:0];
      apb(1'b1, sitd_pkg::OFF_IMG0_CTL, ctl[0]);
      apb(1'b1, sitd_pkg::OFF_IMG1_CTL, ctl[1]);
      apb(1'b1, sitd_pkg::OFF_IMG0_AT, at[0]);
      apb(1'b1, sitd_pkg::OFF_IMG1_AT, at[1]);
      rd(sitd_pkg::OFF_IMG1_AT, at[1] & sitd_pkg::AT_MASK);
      dec(k[5], k[3], k[4], $random(seed));
    end
    lbm.access(1'b1, 1'b0, 1'b0, 1'b0, 32'h00000000);
    fe();
    rd(sitd_pkg::OFF_ERRCS, 32'h00000000);
    apb(1'b1, sitd_pkg::OFF_ERRCS, 32'h80000000);
    fe();
    // A second error while the flag is set must not overwrite the first log
    @(posedge ref_clk);
    {fifoTxnCode, fifoSizeCode} <= 6'h15;
    fe();
    rd(sitd_pkg::OFF_ERRCS, 32'h810000A2);
    rd(sitd_pkg::OFF_AERR, fifoAddr);
    rd(sitd_pkg::OFF_DERR, fifoData);
    apb(1'b1, sitd_pkg::OFF_ERRCS, 32'h01000000);
    rd(sitd_pkg::OFF_ERRCS, 32'h00000000);
    // Status holds the log bit and the decode bus-error bit by now
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, i[0] ? sitd_pkg::OFF_IRQ_STAT : sitd_pkg::OFF_IRQ_MASK, {30'h0, i[1], 1'b1});
      repeat (3) @(posedge ref_clk);
      chk(irq, !i[0]);
    end
    pciRstN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pciRstN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(sitd_pkg::OFF_IMG0_CTL, 32'h00000000);
    rd(sitd_pkg::OFF_IMG0_AT, 32'h00000000);
    rd(sitd_pkg::OFF_IMG0_LOAD, 32'h00000000);
    rd(sitd_pkg::OFF_IMG1_AT, at[1] & sitd_pkg::AT_MASK);
    {img0LoadValid, img0LoadCtl, img0LoadAt} <= {1'b1, 64'hFFFFFFFFFFFFFFFF};
    @(posedge ref_clk);
    img0LoadValid <= 1'b0;
    rd(sitd_pkg::OFF_IMG0_CTL, sitd_pkg::CTL_MASK & 32'hFF7FFFFF);
    rd(sitd_pkg::OFF_IMG0_AT, sitd_pkg::AT_MASK);
    rd(sitd_pkg::OFF_IMG0_LOAD, 32'h00000001);
    rd(12'h004, 32'h00000000);
    chk(lastErr, 1'b1);
    tally_and_finish();
  end
endmodule
bind sitd_top sitd_monitor mon (.ref_clk, .nrst, .paddr, .psel, .penable, .pwrite, .prdata,
  .pready, .bridge_chip_select_n, .accStart, .accWrite, .accBurst, .accAddr, .accResp,
  .accRespValid, .pciAddrOut);
`default_nettype wire
